/* File: hdl/pgt_defines.vh */
/*
 * Register map, field positions, reset values and time-base counts for
 * the pulse generator timing block.
 * Assumes: included by bare name from the design files under hdl/.
 */
`ifndef PGT_DEFINES_VH
`define PGT_DEFINES_VH

// register offsets
`define PGT_OFS_GEN1_DELAY      8'h2f
`define PGT_OFS_GEN1_PERIOD     8'h30
`define PGT_OFS_GEN1_ON_TIME    8'h31
`define PGT_OFS_GEN2_DELAY      8'h32
`define PGT_OFS_GEN2_PERIOD     8'h33
`define PGT_OFS_GEN2_ON_TIME    8'h34
`define PGT_OFS_CONFIG          8'h35
`define PGT_OFS_STATUS          8'h40

// configuration register fields
`define PGT_CFG_GEN1_INVERT     7
`define PGT_CFG_GEN1_ON_SEL     6
`define PGT_CFG_GEN1_PRD_SEL    5
`define PGT_CFG_GEN1_ENABLE     4
`define PGT_CFG_GEN2_INVERT     3
`define PGT_CFG_GEN2_ON_SEL     2
`define PGT_CFG_GEN2_PRD_SEL    1
`define PGT_CFG_GEN2_ENABLE     0

// status register fields
`define PGT_STS_GEN1_OUT        0
`define PGT_STS_GEN2_OUT        1
`define PGT_STS_GEN1_RUN        2
`define PGT_STS_GEN2_RUN        3

// reset values
`define PGT_RST_COUNT           8'h00
`define PGT_RST_CONFIG          8'h00

// time bases
`define PGT_CLK_PERIOD_NS       40
`define PGT_TICK_FAST_MS        1
`define PGT_TICK_SLOW_MS        125
`define PGT_NS_PER_MS           1000000
`define PGT_TICK_FAST_CYCLES \
	(`PGT_TICK_FAST_MS * `PGT_NS_PER_MS / `PGT_CLK_PERIOD_NS)
`define PGT_SLOW_PER_FAST       (`PGT_TICK_SLOW_MS / `PGT_TICK_FAST_MS)

`endif

/* File: hdl/pgt_gen.v */
/*
 * One pulse generator: initial delay, then a repeating period with an
 * on phase of programmable length.
 * Assumes: tick_fast and tick_slow are one-cycle pulses on clk, and
 * tick_slow only ever coincides with a tick_fast.
 */
`timescale 1ns/100ps
`include "pgt_defines.vh"

module pgt_gen (
	// clock and reset
	input  wire       clk,
	input  wire       srst,
	// time bases
	input  wire       tick_fast,
	input  wire       tick_slow,
	// configuration
	input  wire       run_enable,
	input  wire       invert,
	input  wire       on_sel,
	input  wire       prd_sel,
	input  wire [7:0] delay_count,
	input  wire [7:0] period_count,
	input  wire [7:0] on_count,
	// result
	output reg        pulse_out,
	output wire       running
);

	localparam [1:0] ST_IDLE  = 2'b00;
	localparam [1:0] ST_DELAY = 2'b01;
	localparam [1:0] ST_RUN   = 2'b10;

	reg [1:0] state;
	reg [7:0] delay_left;
	reg [7:0] prd_left;
	reg [7:0] on_left;
	reg [7:0] prd_len;

	wire on_tick;
	wire prd_tick;
	wire on_phase;

	// 0 picks the 1 ms tick, 1 the 125 ms tick
	function tick_pick;
		input sel;
		input fast;
		input slow;
		begin
			tick_pick = sel ? slow : fast;
		end
	endfunction

	assign on_tick  = tick_pick(on_sel, tick_fast, tick_slow);
	assign prd_tick = tick_pick(prd_sel, tick_fast, tick_slow);
	assign running  = (state == ST_RUN);
	// a zero period is zero length, so it also clips the on phase
	assign on_phase = running && (on_left != 8'h00) &&
		(prd_len != 8'h00);

	// sequencer: delay counted in period ticks, then period after period;
	// counts are reloaded at each period start so writes land cleanly
	always @(posedge clk) begin
		if (srst || !run_enable) begin
			state      <= ST_IDLE;
			delay_left <= 8'h00;
			prd_left   <= 8'h00;
			on_left    <= 8'h00;
			prd_len    <= 8'h00;
		end else begin
			case (state)
			ST_IDLE: begin
				delay_left <= delay_count;
				state      <= ST_DELAY;
			end
			ST_DELAY: begin
				if (prd_tick) begin
					if (delay_left == 8'h00) begin
						state    <= ST_RUN;
						prd_left <= period_count;
						prd_len  <= period_count;
						on_left  <= on_count;
					end else begin
						delay_left <= delay_left - 8'h01;
					end
				end
			end
			ST_RUN: begin
				if (prd_tick && prd_left <= 8'h01) begin
					prd_left <= period_count;
					prd_len  <= period_count;
					on_left  <= on_count;
				end else begin
					if (prd_tick)
						prd_left <= prd_left - 8'h01;
					if (on_tick && on_left != 8'h00)
						on_left <= on_left - 8'h01;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// output level: off level is the inverted sense of on
	always @(posedge clk) begin
		if (srst)
			pulse_out <= 1'b0;
		else
			pulse_out <= invert ^ on_phase;
	end

endmodule // pgt_gen

/* File: hdl/pgt_top.v */
/*
 * Timing registers and time bases for two pulse generators, with a
 * simple register port and the two generator outputs.
 * Assumes: a single 25 MHz clock, synchronous active-high reset, and a
 * master that uses one-cycle read and write strobes.
 */
// Strobed register access was chosen for this implementation.
// Contract
// - gen1 on-time is 8-bit RW count
// - gen1 on-time counts its selected tick
// - gen2 delay waits from first tick
// - gen2 delay counts period-base ticks
// - gen2 period is count times tick
// - gen2 on-time is count times tick
// - per-generator on and period tick selects
// - disabled generator holds its off level
`timescale 1ns/100ps
`include "pgt_defines.vh"

module pgt_top #(
	parameter [23:0] TICK_FAST_CYCLES = `PGT_TICK_FAST_CYCLES,
	parameter [7:0]  SLOW_PER_FAST    = `PGT_SLOW_PER_FAST
) (
	// clock and reset
	input  wire       clk,
	input  wire       srst,
	// register port
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	// generator outputs
	output wire       gen1_out,
	output wire       gen2_out
);

	// timing registers
	reg [7:0] gen1_delay_count;
	reg [7:0] gen1_period_count;
	reg [7:0] gen1_on_time_count;
	reg [7:0] gen2_initial_delay_count;
	reg [7:0] gen2_period_count;
	reg [7:0] gen2_on_time_count;
	reg [7:0] config_bits;

	// time base state
	reg [23:0] fast_cnt;
	reg [7:0]  slow_cnt;
	reg        tick_fast;
	reg        tick_slow;

	// decoded configuration
	wire gen1_invert;
	wire gen1_on_tick_select;
	wire gen1_period_tick_select;
	wire gen1_run_enable;
	wire gen2_invert;
	wire gen2_on_tick_select;
	wire gen2_period_tick_select;
	wire gen2_run_enable;
	wire gen1_running;
	wire gen2_running;
	wire [7:0] status_bits;
	reg  [7:0] next_rdata;

	assign gen1_invert             = config_bits[`PGT_CFG_GEN1_INVERT];
	assign gen1_on_tick_select     = config_bits[`PGT_CFG_GEN1_ON_SEL];
	assign gen1_period_tick_select = config_bits[`PGT_CFG_GEN1_PRD_SEL];
	assign gen1_run_enable         = config_bits[`PGT_CFG_GEN1_ENABLE];
	assign gen2_invert             = config_bits[`PGT_CFG_GEN2_INVERT];
	assign gen2_on_tick_select     = config_bits[`PGT_CFG_GEN2_ON_SEL];
	assign gen2_period_tick_select = config_bits[`PGT_CFG_GEN2_PRD_SEL];
	assign gen2_run_enable         = config_bits[`PGT_CFG_GEN2_ENABLE];

	// live state seen by software
	assign status_bits = {4'h0, gen2_running, gen1_running,
		gen2_out, gen1_out};

	// register writes; slow-on with fast-period is not checked here, the
	// generator still runs but on_left reloads at each period start, restarting the on phase
	always @(posedge clk) begin
		if (srst) begin
			gen1_delay_count         <= `PGT_RST_COUNT;
			gen1_period_count        <= `PGT_RST_COUNT;
			gen1_on_time_count       <= `PGT_RST_COUNT;
			gen2_initial_delay_count <= `PGT_RST_COUNT;
			gen2_period_count        <= `PGT_RST_COUNT;
			gen2_on_time_count       <= `PGT_RST_COUNT;
			config_bits              <= `PGT_RST_CONFIG;
		end else if (reg_wr) begin
			case (reg_addr)
			`PGT_OFS_GEN1_DELAY: begin
				gen1_delay_count <= reg_wdata;
			end
			`PGT_OFS_GEN1_PERIOD: begin
				gen1_period_count <= reg_wdata;
			end
			`PGT_OFS_GEN1_ON_TIME: begin
				gen1_on_time_count <= reg_wdata;
			end
			`PGT_OFS_GEN2_DELAY: begin
				gen2_initial_delay_count <= reg_wdata;
			end
			`PGT_OFS_GEN2_PERIOD: begin
				gen2_period_count <= reg_wdata;
			end
			`PGT_OFS_GEN2_ON_TIME: begin
				gen2_on_time_count <= reg_wdata;
			end
			`PGT_OFS_CONFIG: begin
				config_bits <= reg_wdata;
			end
			default: begin
				config_bits <= config_bits;
			end
			endcase
		end
	end

	// read mux; unmapped and read-only-elsewhere addresses answer zero
	always @* begin
		next_rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
			`PGT_OFS_GEN1_DELAY:   next_rdata = gen1_delay_count;
			`PGT_OFS_GEN1_PERIOD:  next_rdata = gen1_period_count;
			`PGT_OFS_GEN1_ON_TIME: next_rdata = gen1_on_time_count;
			`PGT_OFS_GEN2_DELAY:   next_rdata = gen2_initial_delay_count;
			`PGT_OFS_GEN2_PERIOD:  next_rdata = gen2_period_count;
			`PGT_OFS_GEN2_ON_TIME: next_rdata = gen2_on_time_count;
			`PGT_OFS_CONFIG:       next_rdata = config_bits;
			`PGT_OFS_STATUS:       next_rdata = status_bits;
			default:               next_rdata = 8'h00;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (srst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= next_rdata;
	end

	// 1 ms time base; free running so both generators share one phase
	always @(posedge clk) begin
		if (srst) begin
			fast_cnt  <= 24'h000000;
			tick_fast <= 1'b0;
		end else if (fast_cnt >= TICK_FAST_CYCLES - 24'h000001) begin
			fast_cnt  <= 24'h000000;
			tick_fast <= 1'b1;
		end else begin
			fast_cnt  <= fast_cnt + 24'h000001;
			tick_fast <= 1'b0;
		end
	end

	// 125 ms time base, built from whole 1 ms ticks so both stay aligned
	always @(posedge clk) begin
		if (srst) begin
			slow_cnt  <= 8'h00;
			tick_slow <= 1'b0;
		end else if (fast_cnt >= TICK_FAST_CYCLES - 24'h000001) begin
			if (slow_cnt >= SLOW_PER_FAST - 8'h01) begin
				slow_cnt  <= 8'h00;
				tick_slow <= 1'b1;
			end else begin
				slow_cnt  <= slow_cnt + 8'h01;
				tick_slow <= 1'b0;
			end
		end else begin
			tick_slow <= 1'b0;
		end
	end

	// generator 1
	pgt_gen u_gen1 (
		.clk          (clk),
		.srst         (srst),
		.tick_fast    (tick_fast),
		.tick_slow    (tick_slow),
		.run_enable   (gen1_run_enable),
		.invert       (gen1_invert),
		.on_sel       (gen1_on_tick_select),
		.prd_sel      (gen1_period_tick_select),
		.delay_count  (gen1_delay_count),
		.period_count (gen1_period_count),
		.on_count     (gen1_on_time_count),
		.pulse_out    (gen1_out),
		.running      (gen1_running)
	);

	// generator 2
	pgt_gen u_gen2 (
		.clk          (clk),
		.srst         (srst),
		.tick_fast    (tick_fast),
		.tick_slow    (tick_slow),
		.run_enable   (gen2_run_enable),
		.invert       (gen2_invert),
		.on_sel       (gen2_on_tick_select),
		.prd_sel      (gen2_period_tick_select),
		.delay_count  (gen2_initial_delay_count),
		.period_count (gen2_period_count),
		.on_count     (gen2_on_time_count),
		.pulse_out    (gen2_out),
		.running      (gen2_running)
	);

endmodule // pgt_top

/* File: tb/pgt_top_assertions.sv */
/* checker for pgt_top: read-back, off levels and waveform lengths
   assumes one-cycle strobes and configs held steady while measured */
`timescale 1ns/100ps
module pgt_top_assertions #(
	parameter [23:0] TICK_FAST_CYCLES = 24'h000004,
	parameter [7:0]  SLOW_PER_FAST    = 8'h03
) (
	// clock and reset
	input wire       clk,
	input wire       srst,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	// generator outputs
	input wire       gen1_out,
	input wire       gen2_out
);
	reg  [7:0]  sh [0:6];
	reg  [7:0]  age;
	reg  [15:0] hi1;
	reg  [15:0] hi2;
	wire [7:0]  idx = reg_addr - 8'h2f;
	wire [7:0]  cfg = sh[6];
	wire [31:0] tf  = TICK_FAST_CYCLES;
	wire [31:0] ts  = TICK_FAST_CYCLES * SLOW_PER_FAST;
	integer     i;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// shadow of writes; age guards checks right after a config change
	always @(posedge clk) begin
		if (srst) begin
			age <= 8'h00;
			hi1 <= 16'h0000;
			hi2 <= 16'h0000;
			for (i = 0; i < 7; i = i + 1)
				sh[i] <= 8'h00;
		end else begin
			hi1 <= gen1_out ? hi1 + 16'h0001 : 16'h0000;
			hi2 <= gen2_out ? hi2 + 16'h0001 : 16'h0000;
			age <= reg_wr ? 8'h00 : age + {7'h00, age != 8'hff};
			if (reg_wr && idx < 8'h07)
				sh[idx[2:0]] <= reg_wdata;
		end
	end
	sequence s_wr_cnt;
		reg_wr && reg_addr >= 8'h31 && reg_addr <= 8'h34;
	endsequence
	sequence s_rd_same;
		reg_rd && reg_addr == $past(reg_addr);
	endsequence
	sequence s_on;
		gen2_out [*4];
	endsequence
	sequence s_off;
		!gen2_out [*4];
	endsequence
	a_reg_readback: assert property (
		s_wr_cnt ##1 s_rd_same |=> reg_rdata == $past(reg_wdata, 2))
		else $error("register read-back differs");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_gen1_off: assert property (
		age >= 3 && !cfg[4] |-> gen1_out == cfg[7])
		else $error("gen1 not at off level");
	a_gen2_off: assert property (
		age >= 3 && !cfg[0] |-> gen2_out == cfg[3])
		else $error("gen2 not at off level");
	a_gen2_wave: assert property (
		$rose(gen2_out) && cfg == 8'h01 && age >= 8 && tf == 4 &&
		sh[4] == 8'h02 && sh[5] == 8'h01 |-> s_on ##1 s_off)
		else $error("gen2 period shape wrong");
	a_gen2_delay: assert property (
		$rose(cfg[0]) && cfg == 8'h01 && sh[3] == 8'h02 &&
		sh[4] == 8'h02 && tf == 4 |-> !gen2_out [*8] ##[3:8] gen2_out)
		else $error("gen2 initial delay wrong");
	a_gen1_on_len: assert property (
		$fell(gen1_out) && age >= 8 && !cfg[7] |->
		hi1 == sh[2] * (cfg[6] ? ts : tf))
		else $error("gen1 on time wrong");
	a_gen2_on_len: assert property (
		$fell(gen2_out) && age >= 8 && !cfg[3] |->
		hi2 == sh[5] * (cfg[2] ? ts : tf))
		else $error("gen2 on time wrong");
endmodule // pgt_top_assertions

bind pgt_top pgt_top_assertions #(
	.TICK_FAST_CYCLES(TICK_FAST_CYCLES),
	.SLOW_PER_FAST(SLOW_PER_FAST)
) chk_u (.clk(clk), .srst(srst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .gen1_out(gen1_out), .gen2_out(gen2_out));

/* File: tb/pgt_top_tb.sv */
/* bench for pgt_top: register rows, then generator waveforms
   assumes time bases shortened to 4 cycles and 3 fast ticks */
`timescale 1ns/100ps
`include "pgt_defines.vh"
module pgt_top_tb;
	localparam [23:0] TF = 24'h000004;
	localparam [7:0]  SP = 8'h03;
	reg        clk;
	reg        srst;
	reg  [7:0] reg_addr;
	reg  [7:0] reg_wdata;
	reg        reg_wr;
	reg        reg_rd;
	wire [7:0] reg_rdata;
	wire       gen1_out;
	wire       gen2_out;
	integer    num_errors;
	integer    n_tests;
	integer    n;
	integer    i;
	reg [23:0] rows [0:4];
	pgt_top #(.TICK_FAST_CYCLES(TF), .SLOW_PER_FAST(SP)) dut_u (
		.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .gen1_out(gen1_out), .gen2_out(gen2_out));
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task chk(input string name, input [15:0] seen, input [15:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("BAD %0s expected %0h seen %0h", name, exp, seen);
			end
		end
	endtask
	task conclude;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, num_errors);
			if (num_errors == 0 && n_tests > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// strobe stays up so back-to-back writes set it once per edge;
	// the next read or the caller lowers it
	task wr(input [7:0] a, input [7:0] d);
		begin
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clk);
		end
	endtask
	// data stand one cycle only, so they are looked at mid-cycle
	task rd(input [7:0] a, input [7:0] exp, input string name);
		begin
			reg_wr <= 1'b0;
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge clk);
			reg_rd <= 1'b0;
			@(negedge clk);
			chk(name, reg_rdata, exp);
			@(posedge clk);
		end
	endtask
	// counts settled samples until an output reaches level v
	task wt(input g, input v, output integer c);
		begin
			c = 0;
			while (((g ? gen2_out : gen1_out) !== v) && c < 400) begin
				@(negedge clk);
				c = c + 1;
			end
			if (c >= 400) begin
				num_errors = num_errors + 1;
				conclude;
			end
		end
	endtask
	task meas(input g, input integer hi, input integer lo);
		begin
			wt(g, 1'b0, n);
			chk("high", n, hi);
			wt(g, 1'b1, n);
			chk("low", n, lo);
		end
	endtask
	initial begin
		srst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		num_errors = 0;
		n_tests = 0;
		rows[0] = {`PGT_OFS_GEN1_ON_TIME, 8'hff, 8'hff};
		rows[1] = {`PGT_OFS_GEN2_DELAY, 8'h00, 8'h00};
		rows[2] = {`PGT_OFS_GEN2_PERIOD, 8'ha5, 8'ha5};
		rows[3] = {`PGT_OFS_GEN2_ON_TIME, 8'h5a, 8'h5a};
		rows[4] = {8'h50, 8'hff, 8'h00};
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 4; i = i + 1)
			rd(8'h31 + i[7:0], 8'h00, "reset");
		$display("reset test done");
		// write then read straight back, no gap
		for (i = 0; i < 5; i = i + 1) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0], "row");
		end
		$display("row test done");
		wr(`PGT_OFS_GEN2_DELAY, 8'h02);
		wr(`PGT_OFS_GEN2_PERIOD, 8'h02);
		wr(`PGT_OFS_GEN2_ON_TIME, 8'h01);
		wr(`PGT_OFS_CONFIG, 8'h01);
		reg_wr <= 1'b0;
		wt(1'b1, 1'b1, n);
		chk("delay", n >= 11 && n <= 16, 1'b1);
		meas(1'b1, TF, TF);
		$display("gen2 test done");
		// let the running pulse checks finish before reconfiguring
		repeat (10) @(posedge clk);
		wr(`PGT_OFS_GEN1_PERIOD, 8'h02);
		wr(`PGT_OFS_GEN1_ON_TIME, 8'h01);
		wr(`PGT_OFS_CONFIG, 8'h70);
		reg_wr <= 1'b0;
		repeat (4) @(negedge clk);
		chk("gen2 off", gen2_out, 1'b0);
		wt(1'b0, 1'b1, n);
		meas(1'b0, TF * SP, TF * SP);
		@(posedge clk);
		wr(`PGT_OFS_CONFIG, 8'h78);
		reg_wr <= 1'b0;
		repeat (4) @(negedge clk);
		chk("gen2 inv", gen2_out, 1'b1);
		$display("gen1 and off level test done");
		// a zero period keeps the output at its off level while running
		wr(`PGT_OFS_GEN2_PERIOD, 8'h00);
		wr(`PGT_OFS_CONFIG, 8'h01);
		reg_wr <= 1'b0;
		repeat (4) @(negedge clk);
		n = 0;
		repeat (40) begin
			@(negedge clk);
			n = n + gen2_out;
		end
		chk("zero period", n, 0);
		$display("zero period test done");
		// reset in mid-run: registers and outputs return to zero
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(`PGT_OFS_GEN2_ON_TIME, 8'h00, "reset mid");
		rd(`PGT_OFS_CONFIG, 8'h00, "reset cfg");
		@(negedge clk);
		chk("reset out", {gen2_out, gen1_out}, 2'b00);
		$display("mid reset test done");
		conclude;
	end
endmodule // pgt_top_tb
